// ### rtl/bssc_pkg.sv
// constants and types of the six-step speed controller
package bssc_pkg;
    // ************************************************
    // register map
    // ************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SPEED_REQ = 8'h04;
    localparam logic [7:0] OFS_GAIN = 8'h08;
    localparam logic [7:0] OFS_LIMIT = 8'h0c;
    localparam logic [7:0] OFS_DEAD = 8'h10;
    localparam logic [7:0] OFS_RAMP = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_SPEED_ACT = 8'h1c;
    localparam logic [7:0] OFS_DUTY = 8'h20;
    localparam logic [7:0] OFS_RAMP_ACT = 8'h24;
    // ctrl bits
    localparam int CTRL_RUN = 0;
    localparam int CTRL_REV = 1;
    localparam int CTRL_BRAKE_EN = 2;
    localparam int CTRL_FAULT_CLR = 3;
    // ************************************************
    // reset values
    // ************************************************
    localparam logic [15:0] GAIN_P_RST = 16'h0100;
    localparam logic [15:0] GAIN_I_RST = 16'h0010;
    localparam logic [7:0] DEAD_RST = 8'h10;
    localparam logic [15:0] RAMP_RST = 16'h0032;
    // ************************************************
    // timing and ranges
    // ************************************************
    localparam int CLK_NS = 8;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int SAMPLE_US = 1000;
    localparam int PWM_PERIOD = 6250;
    localparam int PWM_HALF = PWM_PERIOD / 2;
    localparam logic [15:0] LIMIT_RST = 16'(PWM_HALF);
    localparam logic [15:0] SPEED_MIN_RPM = 16'd300;
    localparam logic [15:0] SPEED_MAX_RPM = 16'd10000;
    localparam int GAIN_SHIFT = 8;
    localparam int POLE_PAIRS = 2;
    localparam int PER_W = 24;
    // ************************************************
    // types
    // ************************************************
    typedef enum logic [1:0] {LEG_OFF, LEG_POS, LEG_NEG} bssc_leg_t;
    typedef struct packed {
        logic [2:0] code;
        logic valid;
        logic edge_seen;
        logic [15:0] rpm;
    } bssc_hall_t;
    typedef struct packed {
        logic hi;
        logic lo;
    } bssc_gate_t;
endpackage : bssc_pkg

// ### rtl/bssc_hall.sv
// hall input capture, period measurement and speed divider
`timescale 1ns/1ps
module bssc_hall #(
    parameter int POLE_PAIRS = bssc_pkg::POLE_PAIRS
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic tick,
    input wire logic [2:0] hall_pin,
    output bssc_pkg::bssc_hall_t hall
);
    localparam int PW = bssc_pkg::PER_W;
    localparam logic [PW-1:0] SPEED_K = PW'(10_000_000 / POLE_PAIRS);
    logic [2:0] s1_q, s2_q, s3_q;
    logic [PW-1:0] per_q, den_q, num_q, rem_q;
    logic [4:0] cnt_q;
    logic [PW:0] trial;
    logic edge_now;
    logic busy_q;
    logic [2:0] arm_q;

    // ************************************************
    // synchroniser and edge
    // ************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= 3'h0;
            s2_q <= 3'h0;
            s3_q <= 3'h0;
            arm_q <= 3'h0;
        end else begin
            s1_q <= hall_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            arm_q <= {arm_q[1:0], 1'b1};
        end
    end
    // reset zeros are no pin level: no false edge before s3 is loaded
    assign edge_now = arm_q[2] && (s2_q != s3_q);

    // ************************************************
    // period between hall edges, in ticks
    // ************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            per_q <= '0;
        end else if (edge_now) begin
            per_q <= '0;
        end else if (tick && per_q != '1) begin
            per_q <= per_q + PW'(1);
        end
    end

    // ************************************************
    // serial divide: rpm = k / period
    // ************************************************
    assign trial = {rem_q, num_q[PW-1]} - {1'b0, den_q};
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            num_q <= '0;
            den_q <= '1;
            rem_q <= '0;
            cnt_q <= 5'h00;
            busy_q <= 1'b0;
            hall <= '0;
        end else begin
            hall.code <= s3_q;
            hall.valid <= (s3_q != 3'h0) && (s3_q != 3'h7);
            hall.edge_seen <= edge_now;
            if (edge_now) begin
                num_q <= SPEED_K;
                den_q <= (per_q == '0) ? PW'(1) : per_q;
                rem_q <= '0;
                cnt_q <= 5'(PW);
                busy_q <= 1'b1;
            end else if (busy_q && cnt_q != 5'h00) begin
                cnt_q <= cnt_q - 5'h01;
                if (!trial[PW]) begin
                    rem_q <= trial[PW-1:0];
                    num_q <= {num_q[PW-2:0], 1'b1};
                end else begin
                    rem_q <= {rem_q[PW-2:0], num_q[PW-1]};
                    num_q <= {num_q[PW-2:0], 1'b0};
                end
            end else if (busy_q) begin
                busy_q <= 1'b0;
                hall.rpm <= (num_q[PW-1:16] != '0) ? 16'hffff
                                                   : num_q[15:0];
            end
            // stalled rotor reads as standstill
            if (per_q == '1) begin
                hall.rpm <= 16'h0000;
            end
        end
    end
endmodule : bssc_hall

// ### rtl/bssc_leg.sv
// one inverter leg: complementary gate pair with dead time
`timescale 1ns/1ps
module bssc_leg (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic active,
    input wire logic want_hi,
    input wire logic [7:0] dead,
    output bssc_pkg::bssc_gate_t gate
);
    bssc_pkg::bssc_gate_t tgt;
    logic [7:0] dcnt_q;

    assign tgt.hi = active && want_hi;
    assign tgt.lo = active && !want_hi;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            gate <= '0;
            dcnt_q <= 8'h00;
        end else if (!active) begin
            gate <= '0;
            dcnt_q <= 8'h00;
        end else if (tgt != gate) begin
            if (gate != '0) begin
                // both off first: shoot-through guard
                gate <= '0;
                dcnt_q <= dead;
            end else if (dcnt_q != 8'h00) begin
                dcnt_q <= dcnt_q - 8'h01;
            end else begin
                gate <= tgt;
            end
        end
    end
endmodule : bssc_leg

// ### rtl/bssc_top.sv
// six-step commutation, speed loop and ahb-lite register slave
`timescale 1ns/1ps
module bssc_top #(
    parameter int SAMPLE_US = bssc_pkg::SAMPLE_US,
    parameter int POLE_PAIRS = bssc_pkg::POLE_PAIRS
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [31:0] haddr,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [2:0] hall_in,
    input wire logic overcurrent,
    input wire logic overvoltage,
    output logic [2:0] gate_hi,
    output logic [2:0] gate_lo,
    output logic brake_out,
    output logic fault_irq
);
    localparam int PW = bssc_pkg::PWM_PERIOD;
    localparam logic [12:0] PWM_LAST = 13'(PW - 1);
    localparam logic [12:0] PWM_MID = 13'(bssc_pkg::PWM_HALF);
    localparam logic [6:0] TICK_LAST = 7'(bssc_pkg::TICK_CYC - 1);
    localparam logic [15:0] SMP_LAST = 16'(SAMPLE_US - 1);

    bssc_pkg::bssc_hall_t hall;
    bssc_pkg::bssc_gate_t [2:0] gate;
    bssc_pkg::bssc_leg_t [2:0] leg;

    logic [1:0] oc_s_q, ov_s_q;
    logic [6:0] tick_cnt_q;
    logic tick;
    logic [15:0] smp_cnt_q;
    logic sample;
    logic [12:0] pwm_cnt_q;
    logic pwm_on;

    logic dph_wr_q, dph_rd_q;
    logic [7:0] dph_addr_q;
    logic [31:0] rd_d;

    logic run_q, rev_q, brake_en_q;
    logic [15:0] speed_req_q, kp_q, ki_q, limit_q, ramp_step_q;
    logic [7:0] dead_q;
    logic fault_q;
    logic fault_clr;

    logic [15:0] target;
    logic [15:0] ramp_q;
    logic signed [17:0] err;
    logic signed [34:0] p_prod, i_prod;
    logic signed [31:0] integ_q, integ_d, u_sum;
    logic signed [15:0] u_q;
    logic signed [31:0] lim_s;
    logic [12:0] cmp_q;
    logic drive_ok;

    // ************************************************
    // pin synchronisers
    // ************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            oc_s_q <= 2'h0;
            ov_s_q <= 2'h0;
        end else begin
            oc_s_q <= {oc_s_q[0], overcurrent};
            ov_s_q <= {ov_s_q[0], overvoltage};
        end
    end

    // ************************************************
    // microsecond tick and pi sampling step
    // ************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_q <= 7'h00;
        end else if (tick) begin
            tick_cnt_q <= 7'h00;
        end else begin
            tick_cnt_q <= tick_cnt_q + 7'h01;
        end
    end
    assign tick = (tick_cnt_q == TICK_LAST);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            smp_cnt_q <= 16'h0000;
        end else if (tick) begin
            smp_cnt_q <= sample ? 16'h0000 : smp_cnt_q + 16'h0001;
        end
    end
    assign sample = tick && (smp_cnt_q == SMP_LAST);

    // ************************************************
    // hall capture
    // ************************************************
    bssc_hall #(
        .POLE_PAIRS(POLE_PAIRS)
    ) u_hall (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .tick(tick),
        .hall_pin(hall_in),
        .hall(hall)
    );

    // ************************************************
    // ahb-lite slave, zero wait states
    // ************************************************
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dph_wr_q <= 1'b0;
            dph_rd_q <= 1'b0;
            dph_addr_q <= 8'h00;
        end else if (hready) begin
            dph_wr_q <= hsel && htrans[1] && hwrite;
            dph_rd_q <= hsel && htrans[1] && !hwrite;
            dph_addr_q <= haddr[7:0];
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        case (haddr[7:0])
            bssc_pkg::OFS_CTRL: begin
                rd_d[2:0] = {brake_en_q, rev_q, run_q};
            end
            bssc_pkg::OFS_SPEED_REQ: begin
                rd_d[15:0] = speed_req_q;
            end
            bssc_pkg::OFS_GAIN: begin
                rd_d = {ki_q, kp_q};
            end
            bssc_pkg::OFS_LIMIT: begin
                rd_d[15:0] = limit_q;
            end
            bssc_pkg::OFS_DEAD: begin
                rd_d[7:0] = dead_q;
            end
            bssc_pkg::OFS_RAMP: begin
                rd_d[15:0] = ramp_step_q;
            end
            bssc_pkg::OFS_STATUS: begin
                rd_d[6:0] = {drive_ok, ov_s_q[1], hall.valid,
                             fault_q, hall.code};
            end
            bssc_pkg::OFS_SPEED_ACT: begin
                rd_d[15:0] = hall.rpm;
            end
            bssc_pkg::OFS_DUTY: begin
                rd_d[15:0] = u_q;
            end
            bssc_pkg::OFS_RAMP_ACT: begin
                rd_d[15:0] = ramp_q;
            end
            default: begin
                rd_d = 32'h0000_0000;
            end
        endcase
    end

    // read data launched in address phase, stands in data phase
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= rd_d;
        end
    end

    // ************************************************
    // host-written controls
    // ************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            run_q <= 1'b0;
            rev_q <= 1'b0;
            brake_en_q <= 1'b0;
            speed_req_q <= 16'h0000;
            kp_q <= bssc_pkg::GAIN_P_RST;
            ki_q <= bssc_pkg::GAIN_I_RST;
            limit_q <= bssc_pkg::LIMIT_RST;
            dead_q <= bssc_pkg::DEAD_RST;
            ramp_step_q <= bssc_pkg::RAMP_RST;
        end else if (dph_wr_q) begin
            case (dph_addr_q)
                bssc_pkg::OFS_CTRL: begin
                    run_q <= hwdata[bssc_pkg::CTRL_RUN];
                    rev_q <= hwdata[bssc_pkg::CTRL_REV];
                    brake_en_q <= hwdata[bssc_pkg::CTRL_BRAKE_EN];
                end
                bssc_pkg::OFS_SPEED_REQ: begin
                    speed_req_q <= hwdata[15:0];
                end
                bssc_pkg::OFS_GAIN: begin
                    kp_q <= hwdata[15:0];
                    ki_q <= hwdata[31:16];
                end
                bssc_pkg::OFS_LIMIT: begin
                    // above half the period would wrap the compare
                    limit_q <= (hwdata[15:0] > bssc_pkg::LIMIT_RST)
                        ? bssc_pkg::LIMIT_RST : hwdata[15:0];
                end
                bssc_pkg::OFS_DEAD: begin
                    dead_q <= hwdata[7:0];
                end
                bssc_pkg::OFS_RAMP: begin
                    ramp_step_q <= hwdata[15:0];
                end
                default: begin
                end
            endcase
        end
    end

    assign fault_clr = dph_wr_q && (dph_addr_q == bssc_pkg::OFS_CTRL)
                       && hwdata[bssc_pkg::CTRL_FAULT_CLR];

    // ************************************************
    // over-current fault and over-voltage brake
    // ************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_q <= 1'b0;
        end else if (oc_s_q[1]) begin
            fault_q <= 1'b1;
        end else if (fault_clr) begin
            fault_q <= 1'b0;
        end
    end
    assign fault_irq = fault_q;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            brake_out <= 1'b0;
        end else begin
            brake_out <= brake_en_q && ov_s_q[1];
        end
    end

    // ************************************************
    // speed ramp
    // ************************************************
    always_comb begin
        target = speed_req_q;
        if (target < bssc_pkg::SPEED_MIN_RPM) begin
            target = bssc_pkg::SPEED_MIN_RPM;
        end else if (target > bssc_pkg::SPEED_MAX_RPM) begin
            target = bssc_pkg::SPEED_MAX_RPM;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ramp_q <= 16'h0000;
        end else if (!run_q) begin
            ramp_q <= 16'h0000;
        end else if (sample) begin
            // one extra bit: a large step must not wrap the compare
            if (17'(ramp_q) + 17'(ramp_step_q) < 17'(target)) begin
                ramp_q <= ramp_q + ramp_step_q;
            end else if (17'(ramp_q) > 17'(target) + 17'(ramp_step_q)) begin
                ramp_q <= ramp_q - ramp_step_q;
            end else begin
                ramp_q <= target;
            end
        end
    end

    // ************************************************
    // pi regulator
    // ************************************************
    assign err = $signed({2'b00, ramp_q}) - $signed({2'b00, hall.rpm});
    assign p_prod = err * $signed({1'b0, kp_q});
    assign i_prod = err * $signed({1'b0, ki_q});
    assign lim_s = $signed({16'h0000, limit_q});

    always_comb begin
        integ_d = integ_q + 32'(i_prod >>> bssc_pkg::GAIN_SHIFT);
        if (integ_d > lim_s) begin
            integ_d = lim_s;
        end else if (integ_d < -lim_s) begin
            integ_d = -lim_s;
        end
        u_sum = integ_d + 32'(p_prod >>> bssc_pkg::GAIN_SHIFT);
        if (u_sum > lim_s) begin
            u_sum = lim_s;
        end else if (u_sum < -lim_s) begin
            u_sum = -lim_s;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            integ_q <= 32'sh0;
            u_q <= 16'sh0;
        end else if (!run_q || fault_q) begin
            integ_q <= 32'sh0;
            u_q <= 16'sh0;
        end else if (sample) begin
            integ_q <= integ_d;
            u_q <= u_sum[15:0];
        end
    end

    // ************************************************
    // bipolar pwm carrier
    // ************************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwm_cnt_q <= 13'h0000;
            cmp_q <= PWM_MID;
        end else if (pwm_cnt_q == PWM_LAST) begin
            pwm_cnt_q <= 13'h0000;
            // reload at period end keeps pulses whole
            cmp_q <= 13'(PWM_MID + u_q);
        end else begin
            pwm_cnt_q <= pwm_cnt_q + 13'h0001;
        end
    end
    assign pwm_on = (pwm_cnt_q < cmp_q);

    // ************************************************
    // commutation table
    // ************************************************
    function automatic bssc_pkg::bssc_leg_t [2:0] commute(
        input logic [2:0] code,
        input logic rev
    );
        bssc_pkg::bssc_leg_t p, n;
        bssc_pkg::bssc_leg_t [2:0] v;
        p = rev ? bssc_pkg::LEG_NEG : bssc_pkg::LEG_POS;
        n = rev ? bssc_pkg::LEG_POS : bssc_pkg::LEG_NEG;
        v = {3{bssc_pkg::LEG_OFF}};
        // index 2 is phase a, 0 is phase c
        case (code)
            3'b110: begin
                v = {p, bssc_pkg::LEG_OFF, n};
            end
            3'b100: begin
                v = {bssc_pkg::LEG_OFF, p, n};
            end
            3'b101: begin
                v = {n, p, bssc_pkg::LEG_OFF};
            end
            3'b001: begin
                v = {n, bssc_pkg::LEG_OFF, p};
            end
            3'b011: begin
                v = {bssc_pkg::LEG_OFF, n, p};
            end
            3'b010: begin
                v = {p, n, bssc_pkg::LEG_OFF};
            end
            default: begin
                v = {3{bssc_pkg::LEG_OFF}};
            end
        endcase
        return v;
    endfunction : commute

    // no alignment: vector follows the live hall code
    assign drive_ok = run_q && !fault_q && !oc_s_q[1]
                      && hall.valid;
    assign leg = drive_ok ? commute(hall.code, rev_q)
                          : {3{bssc_pkg::LEG_OFF}};

    // ************************************************
    // gate pairs
    // ************************************************
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_leg
            bssc_leg u_leg (
                .ref_clk(ref_clk),
                .reset_n(reset_n),
                .active(leg[g] != bssc_pkg::LEG_OFF),
                .want_hi((leg[g] == bssc_pkg::LEG_POS) == pwm_on),
                .dead(dead_q),
                .gate(gate[g])
            );
            assign gate_hi[g] = gate[g].hi;
            assign gate_lo[g] = gate[g].lo;
        end
    endgenerate
endmodule : bssc_top

// ### verification/bssc_asserts.sv
// port assertions of the six-step controller
`timescale 1ns/1ps
module bssc_asserts (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [2:0] hall_in,
    input wire logic overcurrent,
    input wire logic overvoltage,
    input wire logic [2:0] gate_hi,
    input wire logic [2:0] gate_lo,
    input wire logic brake_out,
    input wire logic fault_irq
);
    // ****
    // checks
    // ****
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // six samples cover sync, edge stage and leg register
    sequence s_hall(logic [2:0] c);
        hall_in == c [*6];
    endsequence
    sequence s_oc;
        overcurrent [*4];
    endsequence
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave stalled or erred");
    chk_no_overlap: assert property (!(gate_hi & gate_lo))
        else $error("both gates of a leg on");
    chk_two_legs: assert property ($countones(gate_hi | gate_lo) <= 2)
        else $error("three legs driven");
    chk_b_floats: assert property (s_hall(3'b110) |=>
        !gate_hi[1] && !gate_lo[1]) else $error("leg b driven in 110");
    chk_a_floats: assert property (s_hall(3'b100) |=>
        !gate_hi[2] && !gate_lo[2]) else $error("leg a driven in 100");
    chk_bad_hall: assert property ((hall_in == 3'b000 ||
        hall_in == 3'b111) [*6] |=> (gate_hi | gate_lo) == 3'b000)
        else $error("gates on with invalid hall");
    chk_fault_off: assert property (s_oc |=>
        (gate_hi | gate_lo) == 3'b000) else $error("gates on in fault");
    chk_fault_irq: assert property (s_oc |=> fault_irq)
        else $error("fault flag not raised");
    chk_irq_gates: assert property (fault_irq [*2] |->
        (gate_hi | gate_lo) == 3'b000) else $error("gates on while flagged");
    chk_brake_idle: assert property (!overvoltage [*4] |=> !brake_out)
        else $error("brake on without over-voltage");
endmodule : bssc_asserts
bind bssc_top bssc_asserts u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .hreadyout(hreadyout), .hresp(hresp), .hall_in(hall_in),
    .overcurrent(overcurrent), .overvoltage(overvoltage),
    .gate_hi(gate_hi), .gate_lo(gate_lo), .brake_out(brake_out),
    .fault_irq(fault_irq));

// ### verification/bssc_motor.sv
// hall sensor and power stage model
`timescale 1ns/1ps
module bssc_motor (
    input wire logic ref_clk,
    input wire logic [2:0] hall_set,
    input wire logic oc_set,
    input wire logic [2:0] gate_hi,
    input wire logic [2:0] gate_lo,
    output logic [2:0] hall_in,
    output logic overcurrent
);
    // ****
    // sensors and bus current
    // ****
    // rotor position is chosen by the bench
    always_ff @(posedge ref_clk) begin
        hall_in <= hall_set;
    end
    // a shorted leg trips the bus sense like a real stage
    always_ff @(posedge ref_clk) begin
        overcurrent <= oc_set | (|(gate_hi & gate_lo));
    end
endmodule : bssc_motor

// ### verification/tb.sv
// register and drive scenarios of the six-step controller
`timescale 1ns/1ps
module tb;
    // ****
    // bench
    // ****
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic overvoltage = 1'b0;
    logic oc_set = 1'b0;
    logic [2:0] hall_set = 3'h6;
    logic [31:0] hrdata, rdv;
    logic hreadyout, hresp, brake_out, fault_irq, overcurrent;
    logic [2:0] hall_in, gate_hi, gate_lo, ah, al;
    logic [2:0] codes [6] = '{3'h6, 3'h4, 3'h5, 3'h1, 3'h3, 3'h2};
    logic [2:0] act [6] = '{3'h5, 3'h3, 3'h6, 3'h5, 3'h3, 3'h6};
    int miscompares = 0;
    int tests_run = 0;
    int hc [3];
    always #4 ref_clk = ~ref_clk;
    bssc_top #(.SAMPLE_US(10)) DUT (.ref_clk(ref_clk), .reset_n(reset_n),
        .haddr(haddr), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .hall_in(hall_in), .overcurrent(overcurrent),
        .overvoltage(overvoltage), .gate_hi(gate_hi), .gate_lo(gate_lo),
        .brake_out(brake_out), .fault_irq(fault_irq));
    bssc_motor u_motor (.ref_clk(ref_clk), .hall_set(hall_set),
        .oc_set(oc_set), .gate_hi(gate_hi), .gate_lo(gate_lo),
        .hall_in(hall_in), .overcurrent(overcurrent));
    task automatic complete_run;
        if (miscompares == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    // bounded wait, a stuck slave ends the run
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                miscompares++;
                complete_run();
            end
            @(posedge ref_clk);
        end
    endtask : wait_rdy
    task automatic bus(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        haddr <= {24'h0, a};
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_rdy();
        rdv = hrdata;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        cmp(rdv, e);
    endtask : rd
    // one pwm period of high-side on counts and seen masks
    task automatic count_hi;
        hc = '{0, 0, 0};
        ah = 3'h0;
        al = 3'h0;
        repeat (6250) begin
            @(posedge ref_clk);
            ah = ah | gate_hi;
            al = al | gate_lo;
            for (int i = 0; i < 3; i++) hc[i] += int'(gate_hi[i]);
        end
    endtask : count_hi
    initial begin
        tick(4);
        reset_n <= 1'b1;
        rd(bssc_pkg::OFS_GAIN, 32'h0010_0100);
        rd(bssc_pkg::OFS_LIMIT, 32'h0c35);
        rd(bssc_pkg::OFS_RAMP, 32'h32);
        rd(8'h28, 32'h0);
        bus(bssc_pkg::OFS_DEAD, 1'b1, 32'h4);
        rd(bssc_pkg::OFS_DEAD, 32'h4);
        bus(bssc_pkg::OFS_LIMIT, 1'b1, 32'hffff);
        rd(bssc_pkg::OFS_LIMIT, 32'h0c35);
        bus(bssc_pkg::OFS_LIMIT, 1'b1, 32'h100);
        bus(bssc_pkg::OFS_SPEED_REQ, 1'b1, 32'd1000);
        // no alignment: first vector from the standing hall code
        for (int r = 0; r < 2; r++) begin
            bus(bssc_pkg::OFS_CTRL, 1'b1, {30'h0, r[0], 1'b1});
            // first reload of a positive duty lands within 9000 cycles
            tick(9000);
            count_hi();
            cmp({31'h0, (hc[2] > hc[0]) ^ r[0]}, 32'h1);
            bus(bssc_pkg::OFS_CTRL, 1'b1, 32'h0);
        end
        bus(bssc_pkg::OFS_SPEED_REQ, 1'b1, 32'h14);
        bus(bssc_pkg::OFS_CTRL, 1'b1, 32'h1);
        for (int i = 0; i < 6; i++) begin
            hall_set <= codes[i];
            tick(40);
            count_hi();
            cmp({26'h0, ah, al}, {26'h0, act[i], act[i]});
        end
        for (int i = 0; i < 2; i++) begin
            hall_set <= {3{i[0]}};
            tick(40);
            cmp({29'h0, gate_hi | gate_lo}, 32'h0);
        end
        rd(bssc_pkg::OFS_RAMP_ACT, 32'h12c);
        hall_set <= 3'h6;
        oc_set <= 1'b1;
        tick(5);
        oc_set <= 1'b0;
        tick(5);
        cmp({28'h0, fault_irq, gate_hi | gate_lo}, 32'h8);
        bus(bssc_pkg::OFS_CTRL, 1'b1, 32'h9);
        tick(40);
        cmp({30'h0, fault_irq, |(gate_hi | gate_lo)}, 32'h1);
        bus(bssc_pkg::OFS_CTRL, 1'b1, 32'h5);
        overvoltage <= 1'b1;
        tick(5);
        cmp({31'h0, brake_out}, 32'h1);
        bus(bssc_pkg::OFS_CTRL, 1'b1, 32'h1);
        tick(5);
        cmp({31'h0, brake_out}, 32'h0);
        overvoltage <= 1'b0;
        reset_n <= 1'b0;
        tick(2);
        reset_n <= 1'b1;
        rd(bssc_pkg::OFS_DEAD, 32'h10);
        complete_run();
    end
endmodule : tb
